/* hw/fled_encoder.sv */
// Front LED status encoder: mains LED and bi-colour output LED with blink patterns.
// Assumes all status flags except the power-on request and mains flag come from sys_clk logic;
// the power-on request and mains flag are treated as pins and synchronised.
`timescale 1ns/10ps

module fled_encoder (
  input  wire logic       sys_clk,            // 10 MHz system clock.
  input  wire logic       rst,                // Synchronous active-high reset.
  input  wire logic       clkEn,              // Clock enable; low freezes all state.
  input  wire logic       power_on_request_n, // Power-on request pin, active low.
  input  wire logic       mainsInRange,       // Input line within range (pin level).
  input  wire logic       hotStandby,         // Hot-standby mode active.
  input  wire logic       outOfRegulation,    // Main or standby output out of regulation.
  input  wire logic       otShutdown,         // Overtemperature shutdown.
  input  wire logic       ovShutdown,         // Output overvoltage shutdown.
  input  wire logic       ocShutdown,         // Output overcurrent shutdown.
  input  wire logic       fanErrMajor,        // Fan error above fifteen percent.
  input  wire logic       otWarning,          // Overtemperature warning.
  input  wire logic       fanErrMinor,        // Fan error between five and fifteen percent.
  input  wire logic [3:0] regAddr,            // Register address.
  input  wire logic [7:0] regWrData,          // Register write data.
  input  wire logic       regWr,              // Register write strobe.
  input  wire logic       regRd,              // Register read strobe.
  output logic      [7:0] regRdData,          // Register read data, one cycle later.
  output logic            irq,                // Level interrupt.
  output logic            mainsLedGreen,      // Mains LED green drive.
  output logic            outLedGreen,        // Output LED green drive.
  output logic            outLedYellow        // Output LED yellow drive.
);
  typedef struct packed {
    fled_pkg::fled_pattern_type pat;
    logic                       green;
    logic                       yellow;
    logic                       mains;
    logic [7:0]                 status;
    logic [7:0]                 mask;
    logic [7:0]                 rdData;
    logic [3:0]                 condPrev;
  } fled_enc_state_type;

  fled_enc_state_type state_q, state_d;
  fled_step_if        step ();
  logic [1:0]         pinSync;
  logic               reqOff;
  logic               mainsOk;
  logic               faultAny;
  logic [3:0]         condNow;
  logic [3:0]         condRise;
  logic [7:0]         clrBits;

  // Pin levels cross into the clock domain; the request idles high as if pulled up.
  fled_sync #(.WIDTH(2)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .din     ({mainsInRange, power_on_request_n}),
    .rstVal  (fled_pkg::PIN_RESET),
    .dout    (pinSync)
  );

  fled_prescaler u_presc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .step    (step.source)
  );

  assign reqOff   = pinSync[0];
  assign mainsOk  = pinSync[1];
  assign faultAny = outOfRegulation | otShutdown | ovShutdown | ocShutdown | fanErrMajor;
  assign condNow  = {mainsOk, otWarning, faultAny, reqOff};
  assign condRise = condNow & ~state_q.condPrev;
  assign clrBits  = (regWr && regAddr == fled_pkg::ADDR_STATUS) ? regWrData : 8'h00;

  // Pattern selection, LED drive, event capture and register access in one step.
  always_comb begin
    state_d          = state_q;
    state_d.condPrev = condNow;
    // The first holding condition wins; order fixes the precedence.
    if (reqOff) begin
      state_d.pat = fled_pkg::PAT_OFF_REQ;
    end else if (hotStandby) begin
      state_d.pat = fled_pkg::PAT_STANDBY;
    end else if (faultAny) begin
      state_d.pat = fled_pkg::PAT_FAULT;
    end else if (otWarning) begin
      state_d.pat = fled_pkg::PAT_OT_WARN;
    end else if (fanErrMinor) begin
      state_d.pat = fled_pkg::PAT_FAN_MINOR;
    end else begin
      state_d.pat = fled_pkg::PAT_GOOD;
    end
    // Colour per step of the six-step frame; a 1:2 split is two steps then four.
    case (state_d.pat)
      fled_pkg::PAT_OFF_REQ: begin
        state_d.yellow = (step.stepIdx < fled_pkg::STEPS_HALF);
        state_d.green  = 1'b0;
      end
      fled_pkg::PAT_STANDBY: begin
        state_d.yellow = (step.stepIdx < fled_pkg::STEPS_THIRD);
        state_d.green  = ~(step.stepIdx < fled_pkg::STEPS_THIRD);
      end
      fled_pkg::PAT_FAULT: begin
        state_d.yellow = 1'b1;
        state_d.green  = 1'b0;
      end
      fled_pkg::PAT_OT_WARN: begin
        state_d.yellow = (step.stepIdx < fled_pkg::STEPS_TWO_THIRDS);
        state_d.green  = ~(step.stepIdx < fled_pkg::STEPS_TWO_THIRDS);
      end
      fled_pkg::PAT_FAN_MINOR: begin
        state_d.yellow = (step.stepIdx < fled_pkg::STEPS_HALF);
        state_d.green  = ~(step.stepIdx < fled_pkg::STEPS_HALF);
      end
      fled_pkg::PAT_GOOD: begin
        state_d.yellow = 1'b0;
        state_d.green  = 1'b1;
      end
      default: begin
        state_d.yellow = 1'b1;
        state_d.green  = 1'b0;
      end
    endcase
    // Mains LED follows the line state; undervoltage leaves it dark.
    state_d.mains = mainsOk;
    // Sticky events: a set in the same cycle as a clear wins.
    state_d.status = (state_q.status & ~clrBits) | {4'h0, condRise};
    if (regWr && regAddr == fled_pkg::ADDR_MASK) begin
      state_d.mask = regWrData;
    end
    // Read data stands only in the cycle after the strobe; unmapped reads return zero.
    state_d.rdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        fled_pkg::ADDR_STATUS: state_d.rdData = state_q.status;
        fled_pkg::ADDR_MASK:   state_d.rdData = state_q.mask;
        fled_pkg::ADDR_PAT:    state_d.rdData = {5'h00, state_q.pat};
        fled_pkg::ADDR_COND:   state_d.rdData = {4'h0, condNow};
        default:               state_d.rdData = 8'h00;
      endcase
    end
  end

  // Register all state; reset loads the request-off pattern with both output LED drives low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q          <= '0;
      state_q.pat      <= fled_pkg::PAT_OFF_REQ;
      state_q.mask     <= fled_pkg::MASK_RESET;
      state_q.condPrev <= fled_pkg::COND_RESET;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  // Two separate indicators with independent drives.
  assign mainsLedGreen = state_q.mains;
  assign outLedGreen   = state_q.green;
  assign outLedYellow  = state_q.yellow;
  assign regRdData     = state_q.rdData;
  assign irq           = |(state_q.status & state_q.mask);

  property p_mains_follow;
    @(posedge sys_clk) disable iff (rst)
      clkEn && $past(clkEn) && !$past(rst) |-> mainsLedGreen == $past(pinSync[1]);
  endproperty
  a_mains_follow: assert property (p_mains_follow) else $error("Mains LED wrong.");

  property p_mains_dark;
    @(posedge sys_clk) disable iff (rst)
      clkEn && !pinSync[1] |=> !mainsLedGreen;
  endproperty
  a_mains_dark: assert property (p_mains_dark) else $error("Mains LED lit in UV.");

  property p_prec;
    @(posedge sys_clk) disable iff (rst)
      clkEn && !pinSync[0] && hotStandby |=> state_q.pat == fled_pkg::PAT_STANDBY;
  endproperty
  a_prec: assert property (p_prec) else $error("Standby not chosen.");

  property p_req_blink;
    @(posedge sys_clk) disable iff (rst)
      clkEn && pinSync[0] |=>
        !outLedGreen && (outLedYellow == ($past(step.stepIdx) < fled_pkg::STEPS_HALF));
  endproperty
  a_req_blink: assert property (p_req_blink) else $error("Request blink wrong.");

  property p_standby;
    @(posedge sys_clk) disable iff (rst)
      clkEn && !pinSync[0] && hotStandby |=>
        outLedGreen == ($past(step.stepIdx) >= fled_pkg::STEPS_THIRD);
  endproperty
  a_standby: assert property (p_standby) else $error("Standby blink wrong.");

  property p_fault;
    @(posedge sys_clk) disable iff (rst)
      clkEn && !pinSync[0] && !hotStandby && faultAny |=> outLedYellow && !outLedGreen;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault not solid yellow.");

  property p_otw;
    @(posedge sys_clk) disable iff (rst)
      clkEn && state_d.pat == fled_pkg::PAT_OT_WARN |=>
        outLedYellow == ($past(step.stepIdx) < fled_pkg::STEPS_TWO_THIRDS);
  endproperty
  a_otw: assert property (p_otw) else $error("Warning blink wrong.");

  property p_fan;
    @(posedge sys_clk) disable iff (rst)
      clkEn && state_d.pat == fled_pkg::PAT_FAN_MINOR |=> outLedGreen != outLedYellow &&
        outLedYellow == ($past(step.stepIdx) < fled_pkg::STEPS_HALF);
  endproperty
  a_fan: assert property (p_fan) else $error("Fan blink wrong.");

  property p_good;
    @(posedge sys_clk) disable iff (rst)
      clkEn && state_d.pat == fled_pkg::PAT_GOOD |=> outLedGreen && !outLedYellow;
  endproperty
  a_good: assert property (p_good) else $error("Good not solid green.");

  // The frame index may only move at a step boundary, or the blink ratios drift.
  property p_step;
    @(posedge sys_clk) disable iff (rst)
      clkEn && !$past(rst) && $changed(step.stepIdx) |-> step.stepTick;
  endproperty
  a_step: assert property (p_step) else $error("Step index moved off a boundary.");

  c_fault: cover property (@(posedge sys_clk) disable iff (rst) outLedYellow && !outLedGreen);
  c_good: cover property (@(posedge sys_clk) disable iff (rst) outLedGreen && !outLedYellow);
  c_irq: cover property (@(posedge sys_clk) disable iff (rst) irq);
endmodule

/* hw/fled_pkg.sv */
// Package for the front LED status encoder: pattern codes and timing constants.
// Assumes a 10 MHz system clock.
package fled_pkg;

  // System clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Blink base period in milliseconds; one step of the blink pattern lasts one third of it.
  localparam int unsigned BLINK_PERIOD_MS = 1000;
  // Cycles per blink step, rounded down from a third of the base period.
  localparam int unsigned STEP_CYCLES =
    (BLINK_PERIOD_MS * 1000000 / 3) / CLK_PERIOD_NS;
  // Number of steps in one pattern frame; six covers 1:1, 1:2 and 2:1 splits.
  localparam logic [2:0] FRAME_STEPS = 3'h6;
  // First step index past the yellow phase for the 1:2, 1:1 and 2:1 splits.
  localparam logic [2:0] STEPS_THIRD      = 3'h2;
  localparam logic [2:0] STEPS_HALF       = 3'h3;
  localparam logic [2:0] STEPS_TWO_THIRDS = 3'h4;
  // Reset levels of the synchronised pins {mains, request} and of the condition history.
  localparam logic [1:0] PIN_RESET  = 2'h1;
  localparam logic [3:0] COND_RESET = 4'h1;

  // Status register bit positions.
  localparam int unsigned ST_REQOFF_BIT = 0;
  localparam int unsigned ST_FAULT_BIT = 1;
  localparam int unsigned ST_WARN_BIT  = 2;
  localparam int unsigned ST_MAINS_BIT = 3;
  localparam int unsigned ST_WIDTH     = 4;

  // Register offsets.
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h1;
  localparam logic [3:0] ADDR_PAT    = 4'h2;
  localparam logic [3:0] ADDR_COND   = 4'h3;
  localparam logic [7:0] MASK_RESET  = 8'h00;

  // Output indicator display patterns, in precedence order.
  typedef enum logic [2:0] {
    PAT_OFF_REQ,
    PAT_STANDBY,
    PAT_FAULT,
    PAT_OT_WARN,
    PAT_FAN_MINOR,
    PAT_GOOD
  } fled_pattern_type;

endpackage

/* hw/fled_prescaler.sv */
// Prescaler that divides sys_clk into blink steps and a six-step frame.
// Assumes a 10 MHz clock and a synchronous active-high reset.
`timescale 1ns/10ps
module fled_prescaler (
  input  wire logic   sys_clk, // System clock.
  input  wire logic   rst,     // Synchronous reset.
  input  wire logic   clkEn,   // Clock enable; low freezes state.
  fled_step_if.source step     // Step timing out.
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [2:0]  idx;
    logic        tick;
  } fled_presc_state_type;

  fled_presc_state_type state_q, state_d;

  // Count cycles to a step end, then advance the frame index.
  always_comb begin
    state_d      = state_q;
    state_d.tick = 1'b0;
    if (state_q.cnt == 32'(fled_pkg::STEP_CYCLES - 1)) begin
      state_d.cnt  = 32'h0;
      state_d.tick = 1'b1;
      state_d.idx  = (state_q.idx == fled_pkg::FRAME_STEPS - 3'h1) ? 3'h0 : state_q.idx + 3'h1;
    end else begin
      state_d.cnt = state_q.cnt + 32'h1;
    end
  end

  // Register the state; the enable holds it while low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  assign step.stepTick = state_q.tick & clkEn;
  assign step.stepIdx  = state_q.idx;
endmodule

/* hw/fled_step_if.sv */
// Interface carrying the blink step timing from the prescaler to the encoder.
// Both ends run on sys_clk.
`timescale 1ns/10ps
interface fled_step_if;
  logic       stepTick; // One-cycle pulse at each step boundary.
  logic [2:0] stepIdx;  // Step index within the six-step frame.
  modport source (output stepTick, output stepIdx);
  modport sink   (input stepTick, input stepIdx);
endinterface

/* hw/fled_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to sys_clk.
`timescale 1ns/10ps
module fled_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk, // System clock.
  input  wire logic             rst,     // Synchronous reset.
  input  wire logic             clkEn,   // Clock enable.
  input  wire logic [WIDTH-1:0] din,     // Asynchronous inputs.
  input  wire logic [WIDTH-1:0] rstVal,  // Constant value taken in reset.
  output logic      [WIDTH-1:0] dout     // Synchronised outputs.
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } fled_sync_state_type;

  fled_sync_state_type state_q, state_d;

  // The first stage feeds only the second stage.
  always_comb begin
    state_d      = state_q;
    state_d.meta = din;
    state_d.sync = state_q.meta;
  end

  // Register both stages.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= {rstVal, rstVal};
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  assign dout = state_q.sync;
endmodule

/* verif/fled_led_panel.sv */
// Front panel model: the bi-colour output LED as an operator would watch it.
// Assumes it samples the encoder outputs on sys_clk.
`timescale 1ns/10ps
module fled_led_panel (
  input  wire logic sys_clk,      // System clock.
  input  wire logic rst,          // Synchronous reset.
  input  wire logic mainsLedGreen,// Mains LED drive.
  input  wire logic outLedGreen,  // Output LED green drive.
  input  wire logic outLedYellow, // Output LED yellow drive.
  output logic      bothLit_q     // Sticky: bi-colour LED showed both colours.
);
  // A bi-colour LED shows one colour at a time, so both drives at once is a fault.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bothLit_q <= 1'b0;
    end else if (outLedGreen && outLedYellow) begin
      bothLit_q <= 1'b1;
    end
  end
endmodule

/* verif/front_led_status_encoder_tb_top.sv */
// Testbench for the front LED encoder: register port tasks and condition walks.
// Assumes fled_pkg and the panel model are compiled first.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module front_led_status_encoder_tb_top;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       clkEn = 1'b1;
  logic       reqN = 1'b1;
  logic       mains = 1'b1;
  logic       hotStandby = 1'b0;
  logic [4:0] faultVec = 5'h00;
  logic       otWarning = 1'b0;
  logic       fanErrMinor = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic [7:0] regRdData;
  logic       irq;
  logic       mainsLedGreen;
  logic       outLedGreen;
  logic       outLedYellow;
  logic       bothLit;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         cycleCnt = 0;

  fled_encoder i_fled_encoder (
    .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .power_on_request_n(reqN),
    .mainsInRange(mains), .hotStandby(hotStandby), .outOfRegulation(faultVec[0]),
    .otShutdown(faultVec[1]), .ovShutdown(faultVec[2]), .ocShutdown(faultVec[3]),
    .fanErrMajor(faultVec[4]), .otWarning(otWarning), .fanErrMinor(fanErrMinor),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .irq(irq), .mainsLedGreen(mainsLedGreen),
    .outLedGreen(outLedGreen), .outLedYellow(outLedYellow));

  fled_led_panel i_fled_led_panel (
    .sys_clk(sys_clk), .rst(rst), .mainsLedGreen(mainsLedGreen),
    .outLedGreen(outLedGreen), .outLedYellow(outLedYellow), .bothLit_q(bothLit));

  // The clock toggles every half period of 100 ns.
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // One-cycle read strobe; data stand only in the following cycle.
  task automatic rd(input logic [3:0] a, input logic [7:0] ex);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    `CHK("regRdData", ex, regRdData)
  endtask

  // Pins take three cycles to reach the LEDs, so five cycles is a safe settle.
  task automatic settle();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  // Reads the pattern register and the output LED colours together.
  task automatic pat(input fled_pkg::fled_pattern_type p, input logic y, input logic g);
    settle();
    rd(fled_pkg::ADDR_PAT, {5'h00, p});
    `CHK("outLedYellow", y, outLedYellow)
    `CHK("outLedGreen", g, outLedGreen)
  endtask

  // A hang is cut short well beyond the length of the sequence.
  always @(posedge sys_clk) begin
    cycleCnt++;
    if (cycleCnt == 20000) begin
      error_cnt++;
      results();
    end
  end

  // The whole run stays inside the first blink step, so blinking patterns show yellow.
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    `CHK("outLedYellow", 1'b0, outLedYellow)
    `CHK("mainsLedGreen", 1'b0, mainsLedGreen)
    `CHK("irq", 1'b0, irq)
    rd(fled_pkg::ADDR_STATUS, 8'h00);
    rd(fled_pkg::ADDR_MASK, fled_pkg::MASK_RESET);
    pat(fled_pkg::PAT_OFF_REQ, 1'b1, 1'b0);
    $display("test reset done");
    mains <= 1'b0;
    settle();
    `CHK("mainsLedGreen", 1'b0, mainsLedGreen)
    mains <= 1'b1;
    settle();
    `CHK("mainsLedGreen", 1'b1, mainsLedGreen)
    rd(fled_pkg::ADDR_STATUS, 8'h08);
    `CHK("irq", 1'b0, irq)
    wr(fled_pkg::ADDR_MASK, 8'h08);
    settle();
    `CHK("irq", 1'b1, irq)
    wr(fled_pkg::ADDR_STATUS, 8'h08);
    settle();
    `CHK("irq", 1'b0, irq)
    rd(fled_pkg::ADDR_STATUS, 8'h00);
    wr(fled_pkg::ADDR_MASK, 8'h0F);
    $display("test mains and interrupt done");
    @(posedge sys_clk);
    hotStandby <= 1'b1;
    faultVec <= 5'h01;
    otWarning <= 1'b1;
    fanErrMinor <= 1'b1;
    pat(fled_pkg::PAT_OFF_REQ, 1'b1, 1'b0);
    rd(fled_pkg::ADDR_STATUS, 8'h06);
    wr(fled_pkg::ADDR_STATUS, 8'h06);
    reqN <= 1'b0;
    pat(fled_pkg::PAT_STANDBY, 1'b1, 1'b0);
    hotStandby <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      faultVec <= 5'h01 << i;
      pat(fled_pkg::PAT_FAULT, 1'b1, 1'b0);
    end
    faultVec <= 5'h00;
    pat(fled_pkg::PAT_OT_WARN, 1'b1, 1'b0);
    otWarning <= 1'b0;
    pat(fled_pkg::PAT_FAN_MINOR, 1'b1, 1'b0);
    fanErrMinor <= 1'b0;
    pat(fled_pkg::PAT_GOOD, 1'b0, 1'b1);
    `CHK("irq", 1'b0, irq)
    $display("test precedence done");
    reqN <= 1'b1;
    pat(fled_pkg::PAT_OFF_REQ, 1'b1, 1'b0);
    rd(fled_pkg::ADDR_STATUS, 8'h01);
    `CHK("irq", 1'b1, irq)
    wr(fled_pkg::ADDR_STATUS, 8'h01);
    rd(fled_pkg::ADDR_COND, 8'h09);
    wr(4'hF, 8'hAA);
    rd(4'hF, 8'h00);
    // A low enable freezes the pin path and refuses the mask write.
    clkEn <= 1'b0;
    mains <= 1'b0;
    wr(fled_pkg::ADDR_MASK, 8'h00);
    settle();
    `CHK("mainsLedGreen", 1'b1, mainsLedGreen)
    clkEn <= 1'b1;
    settle();
    `CHK("mainsLedGreen", 1'b0, mainsLedGreen)
    rd(fled_pkg::ADDR_MASK, 8'h0F);
    `CHK("bothLit", 1'b0, bothLit)
    $display("test request off and map done");
    // A reset in mid-run must bring back the power-up state.
    rst <= 1'b1;
    settle();
    `CHK("irq", 1'b0, irq)
    `CHK("mainsLedGreen", 1'b0, mainsLedGreen)
    rst <= 1'b0;
    rd(fled_pkg::ADDR_MASK, fled_pkg::MASK_RESET);
    pat(fled_pkg::PAT_OFF_REQ, 1'b1, 1'b0);
    $display("test freeze and mid-run reset done");
    results();
  end
endmodule
